//--- common/dchp_pkg.sv
package dchp_pkg;

   // ****************************************************************
   // Port addresses
   // ****************************************************************
   localparam logic [7:0] DCHP_ADDR_STATUS_PARAM = 8'h40;
   localparam logic [7:0] DCHP_ADDR_DATA_CMD = 8'h42;
   localparam logic [7:0] DCHP_ADDR_IRQ_CLEAR = 8'h46;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int DCHP_ST_READ_PENDING = 0;
   localparam int DCHP_ST_QUEUE_FULL = 1;
   localparam int DCHP_ST_QUEUE_EMPTY = 2;
   localparam int DCHP_ST_DRAWING = 3;
   localparam int DCHP_ST_DMA = 4;
   localparam int DCHP_ST_VRETRACE = 5;
   localparam int DCHP_ST_HBLANK = 6;
   localparam int DCHP_ST_UNUSED_TOP = 7;
   localparam int DCHP_IRQ_CLEAR_BIT = 0;
   localparam int DCHP_SYNC_DISPLAY_ON_BIT = 0;
   localparam int DCHP_MODE_SELECT_HIGH_BIT = 5;
   localparam int DCHP_FLASHLESS_BIT = 4;
   localparam int DCHP_INTERLACE_BIT = 3;
   localparam int DCHP_DRAM_BIT = 2;
   localparam int DCHP_GRAPHIC_BIT = 1;
   localparam int DCHP_CURSOR_VISIBLE_BIT = 0;
   localparam int DCHP_CURSOR_STEADY_BIT = 1;
   localparam int DCHP_MASTER_BIT = 0;
   localparam int DCHP_ENTRY_CMD_BIT = 8;

   // ****************************************************************
   // Command codes
   // ****************************************************************
   localparam logic [6:0] DCHP_SYNC_SET_OPCODE_HI = 7'h07;
   localparam logic [7:0] DCHP_CURSOR_OPCODE = 8'h70;
   localparam logic [7:0] DCHP_MASTER_OPCODE = 8'h71;

   // ****************************************************************
   // Sizes and reset values
   // ****************************************************************
   localparam int DCHP_BYTE_W = 8;
   localparam int DCHP_QUEUE_DEPTH = 16;
   localparam int DCHP_PARAM_INDEX_W = 4;
   localparam logic DCHP_DISPLAY_ON_RST = 1'b0;
   localparam logic DCHP_CURSOR_STEADY_RST = 1'b0;
   localparam logic DCHP_CURSOR_VISIBLE_RST = 1'b0;
   localparam logic DCHP_MODE_BIT_RST = 1'b0;
   localparam logic DCHP_MASTER_RST = 1'b1;

   typedef enum logic {
      DCHP_PROC_NO_CMD,
      DCHP_PROC_ROUTING
   } dchp_proc_state_t;

endpackage : dchp_pkg

//--- hdl/dchp_cmd_queue.sv
module dchp_cmd_queue #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   // Clock and control
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Fill side
   input wire logic push_i,
   input wire logic [WIDTH-1:0] push_data_i,
   // Drain side
   input wire logic pop_i,
   output logic [WIDTH-1:0] head_o,
   // Fill level
   output logic full_o,
   output logic empty_o,
   output logic [$clog2(DEPTH+1)-1:0] count_o
);

   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH+1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("Queue depth must be a power of two of at least two.");
   end

   logic [WIDTH-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic do_push;
   logic do_pop;

   assign full_o = (count_o == CNT_W'(DEPTH));
   assign empty_o = (count_o == '0);
   assign do_push = ce_i && push_i && !full_o;
   assign do_pop = ce_i && pop_i && !empty_o;
   assign head_o = store[rd_ptr];

   for (genvar e = 0; e < DEPTH; e++) begin : g_entry
      always_ff @(posedge mclk_i) begin
         if (reset_i) begin
            store[e] <= '0;
         end else if (do_push && wr_ptr == PTR_W'(e)) begin
            store[e] <= push_data_i;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + PTR_W'(1);
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + PTR_W'(1);
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         count_o <= '0;
      end else if (do_push && !do_pop) begin
         count_o <= count_o + CNT_W'(1);
      end else if (do_pop && !do_push) begin
         count_o <= count_o - CNT_W'(1);
      end
   end

endmodule : dchp_cmd_queue

//--- hdl/dchp_host_port.sv
module dchp_host_port #(
   parameter int QUEUE_DEPTH = dchp_pkg::DCHP_QUEUE_DEPTH
) (
   // Clock, reset and enable
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Host I/O bus
   input wire logic [7:0] addr_i,
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] rdata_o,
   // Engine status levels
   input wire logic drawing_active_i,
   input wire logic dma_active_i,
   input wire logic vertical_retrace_i,
   input wire logic horizontal_blank_i,
   // Bytes from the engine towards the host
   input wire logic rdq_valid_i,
   input wire logic [7:0] rdq_data_i,
   output logic rdq_ready_o,
   // Routed commands and parameters
   output logic cmd_valid_o,
   output logic [7:0] opcode_o,
   output logic param_valid_o,
   output logic [7:0] param_o,
   output logic [3:0] param_index_o,
   // Interrupt request clear
   output logic irq_clear_o,
   // Display settings
   output logic display_on_o,
   output logic mode_select_high_o,
   output logic char_mode_o,
   output logic mode_unused_o,
   output logic flashless_o,
   output logic interlace_o,
   output logic dram_select_o,
   output logic cursor_steady_o,
   output logic cursor_visible_o,
   output logic master_mode_o
);

   localparam int CNT_W = $clog2(QUEUE_DEPTH+1);
   localparam int ENTRY_W = dchp_pkg::DCHP_BYTE_W + 1;

   if (QUEUE_DEPTH < 2) begin : g_bad_depth
      $error("Command queue depth must be at least two.");
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   logic sel_status_param;
   logic sel_data_cmd;
   logic sel_irq_clear;
   logic host_push;
   logic [ENTRY_W-1:0] push_entry;
   logic queue_full_flag;
   logic queue_empty_flag;
   logic [CNT_W-1:0] queue_count;
   logic [ENTRY_W-1:0] head;
   logic pop;

   assign sel_status_param = (addr_i == dchp_pkg::DCHP_ADDR_STATUS_PARAM);
   assign sel_data_cmd = (addr_i == dchp_pkg::DCHP_ADDR_DATA_CMD);
   assign sel_irq_clear = (addr_i == dchp_pkg::DCHP_ADDR_IRQ_CLEAR);

   // A write into a full queue is dropped; the host is expected to poll first.
   assign host_push = ce_i && wr_i && (sel_status_param || sel_data_cmd) && !queue_full_flag;
   assign push_entry = {sel_data_cmd, wdata_i};

   // ****************************************************************
   // Command queue
   // ****************************************************************
   // host bytes buffered in queue
   dchp_cmd_queue #(
      .WIDTH(ENTRY_W),
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .push_i(host_push),
      .push_data_i(push_entry),
      .pop_i(pop),
      .head_o(head),
      .full_o(queue_full_flag),
      .empty_o(queue_empty_flag),
      .count_o(queue_count)
   );

   assign pop = ce_i && !queue_empty_flag && !host_push;

   // ****************************************************************
   // Read byte register
   // ****************************************************************
   logic read_byte_pending;
   logic [7:0] read_byte;
   logic host_data_read;

   assign host_data_read = ce_i && rd_i && sel_data_cmd;
   // Ready stays low until the host has read the pending byte, so the flag
   // shows a one-cycle gap instead of flipping straight to the next byte.
   assign rdq_ready_o = ce_i && !read_byte_pending;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         read_byte_pending <= 1'b0;
      end else if (ce_i) begin
         // An arriving byte wins, so an unguarded read cannot lose it.
         if (rdq_valid_i && rdq_ready_o) begin
            read_byte_pending <= 1'b1;
         end else if (host_data_read) begin
            read_byte_pending <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         read_byte <= '0;
      end else if (rdq_valid_i && rdq_ready_o) begin
         read_byte <= rdq_data_i;
      end
   end

   // ****************************************************************
   // Status and read data
   // ****************************************************************
   logic [7:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[dchp_pkg::DCHP_ST_READ_PENDING] = read_byte_pending;
      status_word[dchp_pkg::DCHP_ST_QUEUE_FULL] = queue_full_flag;
      status_word[dchp_pkg::DCHP_ST_QUEUE_EMPTY] = queue_empty_flag;
      status_word[dchp_pkg::DCHP_ST_DRAWING] = drawing_active_i;
      status_word[dchp_pkg::DCHP_ST_DMA] = dma_active_i;
      status_word[dchp_pkg::DCHP_ST_VRETRACE] = vertical_retrace_i;
      status_word[dchp_pkg::DCHP_ST_HBLANK] = horizontal_blank_i;
      status_word[dchp_pkg::DCHP_ST_UNUSED_TOP] = 1'b0;
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_o <= '0;
      end else if (ce_i && rd_i) begin
         if (sel_status_param) begin
            rdata_o <= status_word;
         end else if (sel_data_cmd) begin
            rdata_o <= read_byte;
         end else begin
            rdata_o <= '0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         irq_clear_o <= 1'b0;
      end else if (ce_i) begin
         irq_clear_o <= wr_i && sel_irq_clear && wdata_i[dchp_pkg::DCHP_IRQ_CLEAR_BIT];
      end
   end

   // ****************************************************************
   // Command processor
   // ****************************************************************
   dchp_pkg::dchp_proc_state_t proc_state;
   dchp_pkg::dchp_proc_state_t next_proc_state;
   logic pop_is_cmd;
   logic pop_is_param;
   logic [7:0] head_byte;

   assign head_byte = head[7:0];
   assign pop_is_cmd = pop && head[dchp_pkg::DCHP_ENTRY_CMD_BIT];
   assign pop_is_param = pop && !head[dchp_pkg::DCHP_ENTRY_CMD_BIT];

   always_comb begin
      next_proc_state = proc_state;
      if (pop_is_cmd) begin
         next_proc_state = dchp_pkg::DCHP_PROC_ROUTING;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         proc_state <= dchp_pkg::DCHP_PROC_NO_CMD;
      end else if (ce_i) begin
         proc_state <= next_proc_state;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cmd_valid_o <= 1'b0;
         param_valid_o <= 1'b0;
         opcode_o <= '0;
         param_o <= '0;
         param_index_o <= '0;
      end else if (ce_i) begin
         cmd_valid_o <= pop_is_cmd;
         param_valid_o <= 1'b0;
         if (pop_is_cmd) begin
            opcode_o <= head_byte;
            param_index_o <= '0;
         end else if (pop_is_param) begin
            unique case (proc_state)
               dchp_pkg::DCHP_PROC_NO_CMD: begin
                  // Parameters with no command to own them are discarded.
                  param_valid_o <= 1'b0;
               end
               dchp_pkg::DCHP_PROC_ROUTING: begin
                  param_valid_o <= 1'b1;
                  param_o <= head_byte;
                  param_index_o <= param_index_o + 4'h1;
               end
            endcase
         end
      end
   end

   // ****************************************************************
   // Display settings
   // ****************************************************************
   logic first_param;
   logic is_sync_set;
   logic awaiting_first;

   assign is_sync_set = (opcode_o[7:1] == dchp_pkg::DCHP_SYNC_SET_OPCODE_HI);
   assign first_param = pop_is_param && awaiting_first;

   // A flag rather than the index, so that a long parameter run that wraps
   // the index never applies its seventeenth byte as a setting.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         awaiting_first <= 1'b0;
      end else if (pop_is_cmd) begin
         awaiting_first <= 1'b1;
      end else if (pop_is_param) begin
         awaiting_first <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         display_on_o <= dchp_pkg::DCHP_DISPLAY_ON_RST;
      end else if (ce_i && pop_is_cmd && head_byte[7:1] == dchp_pkg::DCHP_SYNC_SET_OPCODE_HI) begin
         display_on_o <= head_byte[dchp_pkg::DCHP_SYNC_DISPLAY_ON_BIT];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         mode_select_high_o <= dchp_pkg::DCHP_MODE_BIT_RST;
         mode_unused_o <= dchp_pkg::DCHP_MODE_BIT_RST;
         flashless_o <= dchp_pkg::DCHP_MODE_BIT_RST;
         interlace_o <= dchp_pkg::DCHP_MODE_BIT_RST;
         dram_select_o <= dchp_pkg::DCHP_MODE_BIT_RST;
      end else if (ce_i && first_param && is_sync_set) begin
         mode_select_high_o <= head_byte[dchp_pkg::DCHP_MODE_SELECT_HIGH_BIT];
         mode_unused_o <= head_byte[dchp_pkg::DCHP_GRAPHIC_BIT];
         flashless_o <= head_byte[dchp_pkg::DCHP_FLASHLESS_BIT];
         interlace_o <= head_byte[dchp_pkg::DCHP_INTERLACE_BIT];
         dram_select_o <= head_byte[dchp_pkg::DCHP_DRAM_BIT];
      end
   end

   assign char_mode_o = mode_select_high_o && !mode_unused_o;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cursor_steady_o <= dchp_pkg::DCHP_CURSOR_STEADY_RST;
         cursor_visible_o <= dchp_pkg::DCHP_CURSOR_VISIBLE_RST;
      end else if (ce_i && first_param && opcode_o == dchp_pkg::DCHP_CURSOR_OPCODE) begin
         cursor_steady_o <= head_byte[dchp_pkg::DCHP_CURSOR_STEADY_BIT];
         cursor_visible_o <= head_byte[dchp_pkg::DCHP_CURSOR_VISIBLE_BIT];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         master_mode_o <= dchp_pkg::DCHP_MASTER_RST;
      end else if (ce_i && first_param && opcode_o == dchp_pkg::DCHP_MASTER_OPCODE) begin
         master_mode_o <= head_byte[dchp_pkg::DCHP_MASTER_BIT];
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);

   a_status_readback: assert property (
      ce_i && rd_i && sel_status_param |=> rdata_o == $past(status_word)
   ) else $error("Status read returned the wrong value.");

   a_full_drops_write: assert property (
      ce_i && wr_i && sel_status_param && queue_full_flag |=> queue_count != '0
   ) else $error("Full queue lost its contents on a dropped write.");

   a_bus_wins_queue: assert property (
      host_push |-> !pop
   ) else $error("Processor popped during a host write.");

   a_processor_drains: assert property (
      ce_i && !queue_empty_flag && !(wr_i && (sel_status_param || sel_data_cmd))
      |=> queue_count == $past(queue_count) - CNT_W'(1)
   ) else $error("Idle processor did not take a queued byte.");

   a_pending_drops: assert property (
      host_data_read && read_byte_pending |=> !read_byte_pending ##1 1'b1
   ) else $error("Read pending flag did not drop after a data read.");

   a_empty_processed: assert property (
      status_word[dchp_pkg::DCHP_ST_QUEUE_EMPTY] |-> queue_count == '0 && !pop
   ) else $error("Empty flag set with unprocessed bytes.");

   a_status_no_effect: assert property (
      ce_i && rd_i && sel_status_param && !wr_i && queue_empty_flag
      |=> queue_empty_flag && read_byte_pending == $past(read_byte_pending)
         || $past(rdq_valid_i && rdq_ready_o)
   ) else $error("Status read disturbed device state.");

   a_sync_display_on: assert property (
      pop_is_cmd && head_byte[7:1] == dchp_pkg::DCHP_SYNC_SET_OPCODE_HI
      |=> display_on_o == $past(head_byte[0])
   ) else $error("Sync command did not set display enable.");

   a_irq_clear_pulse: assert property (
      ce_i && wr_i && sel_irq_clear && wdata_i[0] |=> irq_clear_o ##1 !irq_clear_o || $past(wr_i)
   ) else $error("Interrupt clear strobe missing.");

   a_top_bit_zero: assert property (
      ce_i && rd_i && sel_status_param |=> !rdata_o[7]
   ) else $error("Unused status bit read as one.");

   c_queue_full: cover property (queue_full_flag);
   c_param_routed: cover property (pop_is_cmd ##[1:4] param_valid_o);
   c_data_read: cover property (read_byte_pending ##1 host_data_read);
   c_write_conflict: cover property (host_push && !queue_empty_flag);

endmodule : dchp_host_port

//--- dv/dchp_host_model.sv
module dchp_host_model (
   // Clock
   input wire logic mclk_i,
   // Host I/O bus
   output logic [7:0] addr_o,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] wdata_o,
   input wire logic [7:0] rdata_i,
   // Set when a status poll gives up
   output logic stuck_o
);
   timeunit 1ns;
   timeprecision 1ns;

   // Adds one idle cycle before every bus_rd and bus_wr access to model a slow host.
   logic slow = 1'b0;

   initial begin
      addr_o = 8'h00;
      rd_o = 1'b0;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      stuck_o = 1'b0;
   end

   // ****************************************************************
   // Single bus cycles
   // ****************************************************************
   // Released lines show the inverse value so a stale bus never looks valid.
   task automatic bus_rd(input logic [7:0] addr, output logic [7:0] data);
      if (slow) @(negedge mclk_i);
      @(negedge mclk_i);
      addr_o = addr;
      rd_o = 1'b1;
      @(negedge mclk_i);
      rd_o = 1'b0;
      addr_o = ~addr;
      data = rdata_i;
   endtask : bus_rd

   task automatic bus_wr(input logic [7:0] addr, input logic [7:0] data);
      if (slow) @(negedge mclk_i);
      @(negedge mclk_i);
      addr_o = addr;
      wdata_o = data;
      wr_o = 1'b1;
      @(negedge mclk_i);
      wr_o = 1'b0;
      addr_o = ~addr;
      wdata_o = ~data;
   endtask : bus_wr

   // ****************************************************************
   // Status-guarded accesses and an unguarded burst
   // ****************************************************************
   task automatic await(input int pos, input logic val);
      logic [7:0] st;
      int n;
      n = 0;
      bus_rd(dchp_pkg::DCHP_ADDR_STATUS_PARAM, st);
      while (st[pos] !== val && n < 50) begin
         bus_rd(dchp_pkg::DCHP_ADDR_STATUS_PARAM, st);
         n++;
      end
      if (st[pos] !== val) stuck_o = 1'b1;
   endtask : await

   task automatic put(input logic [7:0] addr, input logic [7:0] data);
      await(dchp_pkg::DCHP_ST_QUEUE_FULL, 1'b0);
      bus_wr(addr, data);
   endtask : put

   task automatic get(output logic [7:0] data);
      await(dchp_pkg::DCHP_ST_READ_PENDING, 1'b1);
      bus_rd(dchp_pkg::DCHP_ADDR_DATA_CMD, data);
   endtask : get

   // Unguarded back-to-back writes, then a status read in the next cycle.
   task automatic burst(input logic [7:0] a [6], input logic [7:0] d [6],
                        output logic [7:0] st);
      for (int i = 0; i < 6; i++) begin
         @(negedge mclk_i);
         addr_o = a[i];
         wdata_o = d[i];
         wr_o = 1'b1;
      end
      @(negedge mclk_i);
      wr_o = 1'b0;
      addr_o = dchp_pkg::DCHP_ADDR_STATUS_PARAM;
      rd_o = 1'b1;
      @(negedge mclk_i);
      rd_o = 1'b0;
      addr_o = 8'hBF;
      st = rdata_i;
   endtask : burst
endmodule : dchp_host_model

//--- dv/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int QD = 4;
   localparam logic [7:0] A_SP = dchp_pkg::DCHP_ADDR_STATUS_PARAM;
   localparam logic [7:0] A_DC = dchp_pkg::DCHP_ADDR_DATA_CMD;
   localparam logic [7:0] A_IRQ = dchp_pkg::DCHP_ADDR_IRQ_CLEAR;

   typedef struct {logic [7:0] cmd; logic [7:0] prm; logic [9:0] exp;} dchp_row_t;

   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic draw_lv = 1'b0, dma_lv = 1'b0, vr_lv = 1'b0, hblank_lv = 1'b0, ce = 1'b1;
   logic rdq_valid = 1'b0, rdq_ready, rd, wr, stuck;
   logic [7:0] rdq_data = 8'h00, addr, wdata, rdata, opcode, prm, st, d;
   logic cmd_valid, param_valid, irq_clear;
   logic [3:0] pidx, last_idx;
   logic [7:0] last_op, last_prm;
   logic [9:0] cfg;
   logic [7:0] ba [6] = '{8'h42, 8'h40, 8'h40, 8'h40, 8'h40, 8'h40};
   logic [7:0] bd [6] = '{8'h71, 8'h01, 8'h11, 8'h21, 8'h31, 8'h41};
   logic [7:0] src [2] = '{8'hA5, 8'h3C};
   int src_n = 0, src_lim = 0, pcount = 0, irq_count = 0, cycles = 0;
   int mismatches = 0, check_count = 0;
   dchp_row_t rows [7] = '{
      '{8'h0F, 8'h20, 10'h381}, '{8'h0E, 8'h1E, 10'h079}, '{8'h0F, 8'h00, 10'h201},
      '{8'h70, 8'h01, 10'h203}, '{8'h70, 8'h02, 10'h205}, '{8'h71, 8'h00, 10'h204},
      '{8'h71, 8'h01, 10'h205}};

   always #25 mclk = ~mclk;

   dchp_host_port #(.QUEUE_DEPTH(QD)) dchp_host_port_i (
      .mclk_i(mclk), .reset_i(reset), .ce_i(ce),
      .addr_i(addr), .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .rdata_o(rdata),
      .drawing_active_i(draw_lv), .dma_active_i(dma_lv),
      .vertical_retrace_i(vr_lv), .horizontal_blank_i(hblank_lv),
      .rdq_valid_i(rdq_valid), .rdq_data_i(rdq_data), .rdq_ready_o(rdq_ready),
      .cmd_valid_o(cmd_valid), .opcode_o(opcode), .param_valid_o(param_valid),
      .param_o(prm), .param_index_o(pidx), .irq_clear_o(irq_clear),
      .display_on_o(cfg[9]), .mode_select_high_o(cfg[8]), .char_mode_o(cfg[7]),
      .mode_unused_o(cfg[6]), .flashless_o(cfg[5]), .interlace_o(cfg[4]),
      .dram_select_o(cfg[3]), .cursor_steady_o(cfg[2]), .cursor_visible_o(cfg[1]),
      .master_mode_o(cfg[0]));

   dchp_host_model dchp_host_model_i (
      .mclk_i(mclk), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata),
      .rdata_i(rdata), .stuck_o(stuck));

   // ****************************************************************
   // Engine source and output monitors
   // ****************************************************************
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (rdq_valid === 1'b1 && rdq_ready === 1'b1) src_n <= src_n + 1;
      if (irq_clear === 1'b1) irq_count <= irq_count + 1;
      if (cmd_valid === 1'b1) begin
         last_op <= opcode;
         pcount <= 0;
      end
      if (param_valid === 1'b1) begin
         last_prm <= prm;
         last_idx <= pidx;
         pcount <= pcount + 1;
      end
   end

   always @(negedge mclk) begin
      rdq_valid <= (src_n < src_lim);
      rdq_data <= (src_n < src_lim) ? src[src_n] : ~rdq_data;
   end

   // The whole run needs a few hundred cycles; this cuts a hang short.
   always @(posedge mclk) begin
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic reset_check();
      reset = 1'b1;
      repeat (3) @(negedge mclk);
      reset = 1'b0;
      check("settings", 10'h001, cfg);
      dchp_host_model_i.bus_rd(A_SP, st);
      check("status", 8'h04, st);
   endtask : reset_check

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      reset_check();
      vr_lv = 1'b1;
      foreach (rows[i]) begin
         dchp_host_model_i.slow = i[0];
         dchp_host_model_i.put(A_DC, rows[i].cmd);
         dchp_host_model_i.put(A_SP, rows[i].prm);
         dchp_host_model_i.await(dchp_pkg::DCHP_ST_QUEUE_EMPTY, 1'b1);
         check("settings", rows[i].exp, cfg);
         check("opcode", rows[i].cmd, last_op);
         check("param", rows[i].prm, last_prm);
         check("index", 4'h1, last_idx);
      end
      for (int i = 0; i < 4; i++) begin
         @(negedge mclk);
         {hblank_lv, vr_lv, dma_lv, draw_lv} = 4'h1 << i;
         dchp_host_model_i.bus_rd(A_SP, st);
         check("status level", 8'h04 | (8'h08 << i), st);
      end
      @(negedge mclk);
      hblank_lv = 1'b0;
      dchp_host_model_i.burst(ba, bd, st);
      check("status full", 8'h02, st);
      dchp_host_model_i.await(dchp_pkg::DCHP_ST_QUEUE_EMPTY, 1'b1);
      check("param count", 16'd4, 16'(pcount));
      check("last param", 8'h41, last_prm);
      check("last index", 4'h4, last_idx);
      src_lim = 2;
      dchp_host_model_i.await(dchp_pkg::DCHP_ST_READ_PENDING, 1'b1);
      dchp_host_model_i.bus_rd(A_SP, st);
      check("pending kept", 8'h05, st);
      dchp_host_model_i.get(d);
      check("data 0", 8'hA5, d);
      dchp_host_model_i.get(d);
      check("data 1", 8'h3C, d);
      dchp_host_model_i.bus_rd(A_SP, st);
      check("pending clear", 8'h04, st);
      dchp_host_model_i.bus_rd(8'h44, st);
      check("unmapped read", 8'h00, st);
      dchp_host_model_i.bus_wr(8'h44, 8'h0E);
      // A command written while the clock enable is low must be lost.
      ce = 1'b0;
      dchp_host_model_i.bus_wr(A_DC, 8'h0E);
      ce = 1'b1;
      dchp_host_model_i.bus_wr(A_IRQ, 8'h00);
      dchp_host_model_i.bus_wr(A_IRQ, 8'h01);
      repeat (2) @(negedge mclk);
      check("irq pulses", 16'd1, 16'(irq_count));
      check("unmapped write", 10'h205, cfg);
      reset_check();
      check("host polls", 1'b0, stuck);
      report_and_stop();
   end
endmodule : tb
